/* rtl/led_pwm_defs.svh */
`ifndef LED_PWM_DEFS_SVH
`define LED_PWM_DEFS_SVH

// command addresses of the intensity registers
`define ADDR_MASTER_NINTH    8'h0e
`define ADDR_PAIR_BASE       8'h10
`define PAIR_REG_COUNT       4

// field positions inside the master / ninth-output register
`define MASTER_MSB           7
`define MASTER_LSB           4
`define NINTH_MSB            3
`define NINTH_LSB            0

// field positions inside a pair register
`define PAIR_ODD_MSB         7
`define PAIR_ODD_LSB         4
`define PAIR_EVEN_MSB        3
`define PAIR_EVEN_LSB        0

// reset values
`define RST_MASTER_NINTH     8'h00
`define RST_PAIR             8'h00
`define RST_READ_DATA        8'h00

// special intensity codes
`define LEVEL_STATIC         4'hf
`define LEVEL_OFF            4'h0
`define SLOT_LAST            4'hf
`define MASTER_STEPS         4'he

// timebase: ref_clk cycles per pwm slot (internal oscillator rate stand-in)
`define OSC_DIV              8'h04

`endif

/* rtl/led_pwm_pkg.sv */
package led_pwm_pkg;

  // one intensity setting
  typedef logic [3:0] nibble_t;

  // timebase state: oscillator stopped or running
  typedef enum logic [1:0] {
    TB_STOP = 2'b01,
    TB_RUN  = 2'b10
  } tb_state_t;

endpackage : led_pwm_pkg

/* rtl/pwm_timebase.sv */
`timescale 1ns/1ps
`include "led_pwm_defs.svh"

module pwm_timebase (
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rstn,
  // master intensity
  input  wire led_pwm_pkg::nibble_t master_level,
  // timebase outputs
  output led_pwm_pkg::nibble_t    slot,
  output logic                    slot_en,
  output logic                    cycle_end,
  output logic                    master_win,
  output logic                    osc_run
);

  led_pwm_pkg::tb_state_t state_r;
  logic [7:0]             div_r;
  led_pwm_pkg::nibble_t   slot_r;
  led_pwm_pkg::nibble_t   mcnt_r;

  // master level zero parks the oscillator
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= led_pwm_pkg::TB_STOP;
    end else begin
      unique case (state_r)
        led_pwm_pkg::TB_STOP: begin
          if (master_level != `LEVEL_OFF) state_r <= led_pwm_pkg::TB_RUN;
        end
        led_pwm_pkg::TB_RUN: begin
          if (master_level == `LEVEL_OFF) state_r <= led_pwm_pkg::TB_STOP;
        end
      endcase
    end
  end

  assign osc_run = (state_r == led_pwm_pkg::TB_RUN);

  // prescaler: one slot enable per OSC_DIV cycles
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      div_r <= 8'h00;
    end else if (!osc_run || div_r == `OSC_DIV - 8'h01) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  assign slot_en   = osc_run && (div_r == `OSC_DIV - 8'h01);
  assign cycle_end = slot_en && (slot_r == `SLOT_LAST);

  // 16-slot pwm counter
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      slot_r <= 4'h0;
    end else if (!osc_run) begin
      slot_r <= 4'h0;
    end else if (slot_en) begin
      slot_r <= slot_r + 4'h1;
    end
  end

  // master window: whole pwm cycles, 15 per master period
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mcnt_r <= 4'h0;
    end else if (!osc_run) begin
      mcnt_r <= 4'h0;
    end else if (cycle_end) begin
      mcnt_r <= (mcnt_r == `MASTER_STEPS) ? 4'h0 : mcnt_r + 4'h1;
    end
  end

  assign slot       = slot_r;
  assign master_win = osc_run && (mcnt_r < master_level);

endmodule : pwm_timebase

/* rtl/led_pwm_blink_intensity.sv */
// Contract
// - With blinking on, settings 0x0-0xE drive low for setting+1 of 16 slots in a phase whose bit is 0, inverted when 1.
// - Setting 0x7 gives 8 low and 8 high slots whatever the phase bit.
// - For 0x0-0x6, bits 0/1 in phases 0/1 give dim then bright, and the reverse pattern swaps them.
// - For 0x8-0xE, bits 0/1 in phases 0/1 give bright then dim, and the reverse pattern swaps them.
// - Setting 0xF is static: held low in a phase whose bit is 0, released in a phase whose bit is 1.
// - Command address 0x0e holds master level in bits 7-4 and ninth-output level in bits 3-0, host writable.
// - Reading 0x0e returns both nibbles unchanged in place.
// - Master level zero gives zero duty, stops the oscillator and leaves all outputs static.
// - Master levels 1-15 give master duty of level/15.
// - Ninth-output levels 0x0-0xE give duty (level+1)/16 with its level bit 0, (15-level)/16 with it 1, and 0xF a static output.
// - With blinking off, each output uses only its phase-0 bit to pick normal or inverted duty.
// - Per-output levels pack two per register from 0x10, odd output high nibble, even output low nibble.
`timescale 1ns/1ps
`include "led_pwm_defs.svh"

module led_pwm_blink_intensity (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  // register port, command addressed
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr_en,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd_en,
  output logic      [7:0] reg_rdata,
  output logic            reg_rd_valid,
  output logic            reg_rd_hit,
  // blink control from the blink block
  input  wire logic       blink_enable,
  input  wire logic       blink_phase,
  input  wire logic [7:0] phase0_bits,
  input  wire logic [7:0] phase1_bits,
  // ninth output level bit from its own register
  input  wire logic       ninth_output_bit,
  // open-drain port outputs, oe high sinks current
  output logic      [7:0] port_o,
  output logic      [7:0] port_oe,
  output logic            ninth_output_o,
  output logic            ninth_output_oe,
  // timebase status
  output logic            osc_running
);

  // host-visible storage
  logic [7:0]           master_ninth_r;
  logic [7:0]           pair_r [`PAIR_REG_COUNT];
  // settings in use for the current pwm cycle
  logic [7:0]           master_ninth_act_r;
  logic [7:0]           pair_act_r [`PAIR_REG_COUNT];
  // timebase
  led_pwm_pkg::nibble_t slot;
  logic                 slot_en;
  logic                 cycle_end;
  logic                 master_win;
  logic                 osc_run;
  // per-output decisions
  logic [7:0]           inv_sel;
  logic [7:0]           port_low_nxt;
  logic                 ninth_low_nxt;
  logic [7:0]           port_oe_r;
  logic                 ninth_oe_r;
  logic [7:0]           rdata_r;
  logic                 rd_valid_r;
  logic                 rd_hit_r;

  // true when the address falls in the pair register block
  function automatic logic is_pair_addr(input logic [7:0] addr);
    is_pair_addr = (addr >= `ADDR_PAIR_BASE) &&
                   (addr < `ADDR_PAIR_BASE + 8'(`PAIR_REG_COUNT));
  endfunction : is_pair_addr

  // index of a pair register from its address
  function automatic logic [1:0] pair_index(input logic [7:0] addr);
    logic [7:0] diff;
    diff       = addr - `ADDR_PAIR_BASE;
    pair_index = diff[1:0];
  endfunction : pair_index

  // intensity nibble of output n from the pair registers
  function automatic led_pwm_pkg::nibble_t level_of(input logic [7:0] pair, input logic odd);
    level_of = odd ? pair[`PAIR_ODD_MSB:`PAIR_ODD_LSB] : pair[`PAIR_EVEN_MSB:`PAIR_EVEN_LSB];
  endfunction : level_of

  // sink decision for one output in the current slot
  // inv=0: low for level+1 slots; inv=1: low for the other 15-level slots
  // level 0xf skips pwm and the master window entirely
  function automatic logic sink_now(input led_pwm_pkg::nibble_t level,
                                    input logic                 inv,
                                    input led_pwm_pkg::nibble_t cnt,
                                    input logic                 win);
    logic pwm_low;
    pwm_low = 1'b0;
    if (level == `LEVEL_STATIC) begin
      sink_now = !inv;
    end else begin
      pwm_low  = inv ? (cnt > level) : (cnt <= level);
      sink_now = win && pwm_low;
    end
  endfunction : sink_now

  // timebase, stopped while master level is zero
  pwm_timebase u_timebase (
    .ref_clk      (ref_clk),
    .rstn         (rstn),
    .master_level (master_ninth_r[`MASTER_MSB:`MASTER_LSB]),
    .slot         (slot),
    .slot_en      (slot_en),
    .cycle_end    (cycle_end),
    .master_win   (master_win),
    .osc_run      (osc_run)
  );

  // master / ninth register write
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      master_ninth_r <= `RST_MASTER_NINTH;
    end else if (reg_wr_en && reg_addr == `ADDR_MASTER_NINTH) begin
      master_ninth_r <= reg_wdata;
    end
  end

  // pair register writes, two outputs per byte
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `PAIR_REG_COUNT; i++) begin
        pair_r[i] <= `RST_PAIR;
      end
    end else if (reg_wr_en && is_pair_addr(reg_addr)) begin
      pair_r[pair_index(reg_addr)] <= reg_wdata;
    end
  end

  // readback, one cycle after the strobe; other addresses belong elsewhere
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r    <= `RST_READ_DATA;
      rd_valid_r <= 1'b0;
      rd_hit_r   <= 1'b0;
    end else begin
      rd_valid_r <= reg_rd_en;
      if (reg_rd_en) begin
        if (reg_addr == `ADDR_MASTER_NINTH) begin
          rdata_r  <= master_ninth_r;
          rd_hit_r <= 1'b1;
        end else if (is_pair_addr(reg_addr)) begin
          rdata_r  <= pair_r[pair_index(reg_addr)];
          rd_hit_r <= 1'b1;
        end else begin
          rdata_r  <= `RST_READ_DATA;
          rd_hit_r <= 1'b0;
        end
      end
    end
  end

  assign reg_rdata    = rdata_r;
  assign reg_rd_valid = rd_valid_r;
  assign reg_rd_hit   = rd_hit_r;

  // pair and ninth levels move into use only at a cycle boundary, so their writes never
  // leave a runt pulse; the master level acts at once; while stopped they follow at once
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      master_ninth_act_r <= `RST_MASTER_NINTH;
      for (int i = 0; i < `PAIR_REG_COUNT; i++) begin
        pair_act_r[i] <= `RST_PAIR;
      end
    end else if (cycle_end || !osc_run) begin
      master_ninth_act_r <= master_ninth_r;
      for (int i = 0; i < `PAIR_REG_COUNT; i++) begin
        pair_act_r[i] <= pair_r[i];
      end
    end
  end

  // phase bit per output: blink on picks by current phase, else phase 0 only
  always_comb begin
    if (blink_enable) begin
      inv_sel = blink_phase ? phase1_bits : phase0_bits;
    end else begin
      inv_sel = phase0_bits;
    end
  end

  // per-output sink decision; inverted duty swaps dim and bright by setting
  always_comb begin
    port_low_nxt = 8'h00;
    for (int n = 0; n < 8; n++) begin
      port_low_nxt[n] = sink_now(level_of(pair_act_r[n / 2], n[0]), inv_sel[n], slot,
                                 master_win);
    end
  end

  // ninth output uses its own nibble and its own level bit, no blink phase
  always_comb begin
    ninth_low_nxt = sink_now(master_ninth_act_r[`NINTH_MSB:`NINTH_LSB], ninth_output_bit, slot,
                             master_win);
  end

  // registered pin enables; with the oscillator stopped the window is
  // closed, so pwm outputs sit released and 0xf outputs keep their level
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      port_oe_r  <= 8'h00;
      ninth_oe_r <= 1'b0;
    end else begin
      port_oe_r  <= port_low_nxt;
      ninth_oe_r <= ninth_low_nxt;
    end
  end

  // open drain: data always low, the enable does the work
  assign port_o          = 8'h00;
  assign port_oe         = port_oe_r;
  assign ninth_output_o  = 1'b0;
  assign ninth_output_oe = ninth_oe_r;
  assign osc_running     = osc_run;

endmodule : led_pwm_blink_intensity

/* dv/led_load.sv */
`timescale 1ns/1ps
// lamp bank on the open-drain pins, ninth output at bit 8
module led_load (
  // clock and control
  input  wire logic       ref_clk,
  input  wire logic       clr,
  // sink enables from the pins
  input  wire logic [8:0] sink,
  // clocks lit per lamp
  output int unsigned     on_cnt [9]
);
  // the eye averages, so lit clocks are summed rather than edges timed
  always_ff @(posedge ref_clk) begin
    for (int n = 0; n < 9; n++) begin
      on_cnt[n] <= clr ? 0 : on_cnt[n] + 32'(sink[n]);
    end
  end
endmodule : led_load

/* dv/led_pwm_asserts.sv */
`timescale 1ns/1ps
module led_pwm_asserts (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       rstn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr_en,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rd_en,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rd_valid,
  input wire logic       reg_rd_hit,
  // pins and status
  input wire logic [7:0] port_o,
  input wire logic       ninth_output_o,
  input wire logic       osc_running
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // write then read of the shared level register
  sequence s_wr_lvl;
    reg_wr_en && reg_addr == 8'h0e;
  endsequence
  sequence s_rd_lvl;
    reg_rd_en && !reg_wr_en && reg_addr == 8'h0e;
  endsequence
  a_rd_answer: assert property (reg_rd_en |=> reg_rd_valid) else $error("read answer missing");
  a_no_stray: assert property (!reg_rd_en |=> !reg_rd_valid) else $error("stray read answer");
  a_rd_holds: assert property (!reg_rd_en |=> $stable(reg_rdata) && $stable(reg_rd_hit))
    else $error("read data moved");
  a_readback_same: assert property (s_wr_lvl ##1 s_rd_lvl |=> reg_rdata == $past(reg_wdata, 2))
    else $error("readback differs");
  a_level_hit: assert property (s_rd_lvl |=> reg_rd_hit) else $error("level register missed");
  a_unmapped_rd: assert property (reg_rd_en && reg_addr == 8'h20 |=> !reg_rd_hit && reg_rdata == 8'h00)
    else $error("unmapped read answered");
  // stored level lands on the write edge, the run state follows one edge later
  a_osc_start: assert property (s_wr_lvl and reg_wdata[7:4] != 4'h0 |-> ##2 osc_running)
    else $error("oscillator not started");
  a_osc_stop: assert property (s_wr_lvl and reg_wdata[7:4] == 4'h0 |-> ##2 !osc_running)
    else $error("oscillator not stopped");
  a_open_drain: assert property (port_o == 8'h00 && !ninth_output_o) else $error("pin driven high");
endmodule : led_pwm_asserts

bind led_pwm_blink_intensity led_pwm_asserts u_chk (.ref_clk, .rstn, .reg_addr, .reg_wr_en, .reg_wdata,
  .reg_rd_en, .reg_rdata, .reg_rd_valid, .reg_rd_hit, .port_o, .ninth_output_o, .osc_running);

/* dv/tb.sv */
`timescale 1ns/1ps
module tb;
  logic        ref_clk, rstn, reg_wr_en, reg_rd_en, reg_rd_valid, reg_rd_hit, clr;
  logic        blink_enable, blink_phase, ninth_output_bit, ninth_output_o, ninth_output_oe, osc_running;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, phase0_bits, phase1_bits, port_o, port_oe;
  int unsigned on_cnt [9];
  int          bad_count, checks_done;
  // levels of outputs 0..7
  logic [3:0]  lvl [8] = '{4'h0, 4'h6, 4'h7, 4'h8, 4'he, 4'hf, 4'h3, 4'hb};
  // per case: level reg, phase0, phase1, {blink on, phase, ninth bit, 0}
  logic [31:0] cs [6] = '{32'hf500ff00, 32'hf5ff0002, 32'hf500ff0c, 32'hf50ff008, 32'h55ff550e, 32'h0f000000};

  led_pwm_blink_intensity dut (.ref_clk, .rstn, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en, .reg_rdata,
    .reg_rd_valid, .reg_rd_hit, .blink_enable, .blink_phase, .phase0_bits, .phase1_bits, .ninth_output_bit,
    .port_o, .port_oe, .ninth_output_o, .ninth_output_oe, .osc_running);
  led_load u_led (.ref_clk, .clr, .sink({ninth_output_oe, port_oe}), .on_cnt);

  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : cmp

  // strobes stay up at exit so accesses can run back to back
  task automatic drive(logic rd, logic [7:0] a, logic [7:0] d);
    reg_wr_en = !rd;
    reg_rd_en = rd;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge ref_clk);
    #2;
  endtask : drive

  task automatic rd(logic [7:0] a, logic [7:0] ed, logic eh);
    drive(1'b1, a, 8'h00);
    cmp("rd_valid", 1, reg_rd_valid);
    cmp("rdata", ed, reg_rdata);
    cmp("rd_hit", eh, reg_rd_hit);
  endtask : rd

  task automatic idle;
    reg_wr_en = 0;
    reg_rd_en = 0;
    @(posedge ref_clk);
    #2;
  endtask : idle

  // settle past a pwm cycle end, then count one whole master period
  task automatic meas(logic [3:0] m, logic [3:0] g);
    logic [3:0]  lv;
    logic        inv;
    int unsigned e;
    repeat (130) @(posedge ref_clk);
    #2 clr = 1;
    @(posedge ref_clk);
    #2 clr = 0;
    repeat (960) @(posedge ref_clk);
    #2;
    for (int n = 0; n < 9; n++) begin
      lv  = n < 8 ? lvl[n] : g;
      inv = n < 8 ? (blink_enable && blink_phase ? phase1_bits[n] : phase0_bits[n]) : ninth_output_bit;
      e   = lv == 4'hf ? (inv ? 0 : 960) : 4 * m * (inv ? 15 - lv : lv + 1);
      cmp($sformatf("lit clocks %0d", n), e, on_cnt[n]);
    end
  endtask : meas

  task automatic results;
    if (bad_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  initial begin
    ref_clk = 0;
    forever #10 ref_clk = ~ref_clk;
  end

  initial begin
    {rstn, reg_wr_en, reg_rd_en, blink_enable, blink_phase, ninth_output_bit, clr} = '0;
    {reg_addr, reg_wdata, phase0_bits, phase1_bits} = '0;
    bad_count = 0;
    checks_done = 0;
    repeat (12) @(posedge ref_clk);
    #2 rstn = 1;
    cmp("osc_running", 0, osc_running);
    rd(8'h0e, 8'h00, 1);
    for (int k = 0; k < 4; k++) drive(0, 8'(8'h10 + k), {lvl[2*k+1], lvl[2*k]});
    drive(0, 8'h14, 8'hff);
    drive(0, 8'h0e, 8'hf5);
    rd(8'h0e, 8'hf5, 1);
    for (int k = 0; k < 4; k++) rd(8'(8'h10 + k), {lvl[2*k+1], lvl[2*k]}, 1);
    rd(8'h20, 8'h00, 0);
    rd(8'h14, 8'h00, 0);
    idle;
    // each case rewrites master and ninth levels, then measures lit time
    for (int c = 0; c < 6; c++) begin
      drive(0, 8'h0e, cs[c][31:24]);
      idle;
      {phase0_bits, phase1_bits} = cs[c][23:8];
      {blink_enable, blink_phase, ninth_output_bit} = cs[c][3:1];
      cmp("osc_running", cs[c][31:28] != 4'h0, osc_running);
      meas(cs[c][31:28], cs[c][27:24]);
    end
    results;
  end
endmodule : tb
